//--- common/uart_flow_pkg.sv
package uart_flow_pkg;

  // Register byte offsets
  localparam logic [5:0] OFF_SERIAL_CONTROL = 6'h00;
  localparam logic [5:0] OFF_SOFT_FLOW      = 6'h04;
  localparam logic [5:0] OFF_FLOW_CHARS     = 6'h08;
  localparam logic [5:0] OFF_DIVISOR        = 6'h0C;
  localparam logic [5:0] OFF_FIFO_LEVEL     = 6'h10;
  localparam logic [5:0] OFF_SERIAL_FLAG    = 6'h14;
  localparam logic [5:0] OFF_RAW_STATUS     = 6'h18;
  localparam logic [5:0] OFF_INT_MASK       = 6'h1C;
  localparam logic [5:0] OFF_MASKED_STATUS  = 6'h20;

  // Serial control register bits
  localparam int BIT_UART_ENABLE  = 0;
  localparam int BIT_REQUEST_FLOW = 1;
  localparam int BIT_CLEAR_FLOW   = 2;
  localparam int BIT_OVERSAMPLE   = 3;

  // Soft flow control register fields
  localparam int BIT_SOFT_MASTER  = 0;
  localparam int POS_RX_MODE      = 1;
  localparam int POS_TX_MODE      = 3;
  localparam int BIT_RESUME_ANY   = 5;
  localparam int BIT_SPECIAL_CHAR = 6;
  localparam int POS_RESUME_STRAT = 7;

  // Character register byte positions
  localparam int POS_RESUME_FIRST  = 0;
  localparam int POS_RESUME_SECOND = 8;
  localparam int POS_PAUSE_FIRST   = 16;
  localparam int POS_PAUSE_SECOND  = 24;

  // Divisor fields and fill levels
  localparam int POS_DIV_FRAC  = 16;
  localparam int DIV_INT_W     = 16;
  localparam int DIV_FRAC_W    = 6;
  localparam int FILL_W        = 7;
  localparam int POS_TRIGGER   = 8;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;

  // Last oversample count per bit for each ratio
  localparam logic [3:0] OVS_LAST_16 = 4'hF;
  localparam logic [3:0] OVS_LAST_8  = 4'h7;

  // Match and insert mode codes
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_FIRST  = 2'h1;
  localparam logic [1:0] MODE_SECOND = 2'h2;
  localparam logic [1:0] MODE_BOTH   = 2'h3;

  // Reset values
  localparam logic [31:0] RST_SERIAL_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_SOFT_FLOW      = 32'h0000_0000;
  localparam logic [31:0] RST_FLOW_CHARS     = 32'h1311_1311;
  localparam logic [31:0] RST_DIVISOR        = 32'h0000_0001;
  localparam logic [31:0] RST_FIFO_LEVEL     = 32'h0000_2020;

  // Received character with its status nibble
  typedef struct packed {
    logic [3:0] status;
    logic [7:0] data;
  } rx_char_s;

  // Programmed flow characters
  typedef struct packed {
    logic [7:0] pauseSecond;
    logic [7:0] pauseFirst;
    logic [7:0] resumeSecond;
    logic [7:0] resumeFirst;
  } flow_chars_s;

  // Automatic insertion sequencer
  typedef enum logic [1:0] {
    INS_IDLE,
    INS_FIRST,
    INS_SECOND,
    INS_DRAIN
  } insert_state_e;

endpackage

//--- design/baud_tick_gen.sv
`timescale 1ns/1ps
module baud_tick_gen
  import uart_flow_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Divisor settings
  input  wire logic [DIV_INT_W-1:0]  divisorInt,
  input  wire logic [DIV_FRAC_W-1:0] divisorFrac,
  input  wire logic                  oversampleSel,
  // Tick outputs
  output logic                       sampleTick,
  output logic                       bitTick
);

  logic [DIV_INT_W-1:0]  count;
  logic [DIV_FRAC_W-1:0] fracAcc;
  logic                  stretch;
  logic [3:0]            sampleCount;
  logic [DIV_FRAC_W:0]   fracSum;
  logic                  periodEnd;

  // One extra clock whenever the fraction accumulator overflows
  assign fracSum   = {1'b0, fracAcc} + {1'b0, divisorFrac};
  assign periodEnd = ({1'b0, count} + 17'h00001 >= {1'b0, divisorInt} + {16'h0000, stretch});

  // Fractional divider producing the oversample tick
  always_ff @(posedge clk) begin
    if (rst) begin
      count      <= 16'h0000;
      fracAcc    <= 6'h00;
      stretch    <= 1'b0;
      sampleTick <= 1'b0;
    end else if (periodEnd) begin
      count      <= 16'h0000;
      fracAcc    <= fracSum[DIV_FRAC_W-1:0];
      stretch    <= fracSum[DIV_FRAC_W];
      sampleTick <= 1'b1;
    end else begin
      count      <= count + 16'h0001;
      sampleTick <= 1'b0;
    end
  end

  // Divide by sixteen or eight oversample ticks per bit
  always_ff @(posedge clk) begin
    if (rst) begin
      sampleCount <= 4'h0;
      bitTick     <= 1'b0;
    end else if (sampleTick) begin
      bitTick     <= (sampleCount >= (oversampleSel ? OVS_LAST_8 : OVS_LAST_16));
      sampleCount <= (sampleCount >= (oversampleSel ? OVS_LAST_8 : OVS_LAST_16)) ?
                     4'h0 : sampleCount + 4'h1;
    end else begin
      bitTick <= 1'b0;
    end
  end

endmodule

//--- design/uart_flow_control.sv
`timescale 1ns/1ps
module uart_flow_control (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Avalon-MM register slave
  input  wire logic [5:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // Receive path from deframer and to receive FIFO
  input  wire logic                       rxValid,
  input  wire uart_flow_pkg::rx_char_s    rxChar,
  input  wire logic [uart_flow_pkg::FILL_W-1:0] rxFill,
  output logic                            rxStore,
  output uart_flow_pkg::rx_char_s         rxStoreChar,
  // Transmit path from transmit FIFO and to framer
  input  wire logic                       txFifoEmpty,
  input  wire logic [7:0]                 txFifoData,
  input  wire logic                       txBusy,
  output logic                            txFifoPop,
  output logic                            txStart,
  output logic [7:0]                      txByte,
  // Baud ticks for framer and deframer
  output logic                            sampleTick,
  output logic                            bitTick,
  // Modem pins
  input  wire logic                       ctsN,
  output logic                            rtsN,
  // Pause interrupt
  output logic                            pauseIrq
);
  import uart_flow_pkg::*;

  logic [31:0]         serialControl;
  logic [31:0]         softFlow;
  flow_chars_s         flowChars;
  logic [31:0]         divisor;
  logic [31:0]         fifoLevel;
  logic                pauseRaw;
  logic                pauseMask;
  logic                ack;
  logic                regWrite;
  logic                uartEnable;
  logic                softMaster;
  logic [1:0]          rxMode;
  logic [1:0]          txMode;
  logic [1:0]          resumeMode;
  logic [FILL_W-1:0]   watermark;
  logic [FILL_W-1:0]   triggerLevel;
  logic                txPaused;
  logic                pausePartial;
  logic                resumePartial;
  logic [1:0]          pauseHit;
  logic [1:0]          resumeHit;
  logic                matchActive;
  logic                specialHit;
  logic                pauseSet;
  logic                resumeSet;
  logic                storeChar;
  logic                remoteHalted;
  insert_state_e       insState;
  logic                insResume;
  logic [1:0]          insMode;
  logic                startGuard;
  logic                txIdle;
  logic                ctsOk;
  logic                swTxActive;

  // Returns {full match, first half of a pair} for one character class
  function automatic logic [1:0] charMatch(input logic [1:0] mode, input logic [7:0] data,
                                           input logic [7:0] first, input logic [7:0] second,
                                           input logic partial);
    logic [1:0] hit;
    hit = 2'b00;
    case (mode)
      MODE_FIRST:  hit = {data == first, 1'b0};
      MODE_SECOND: hit = {data == second, 1'b0};
      MODE_BOTH:   hit = partial ? {data == second, 1'b0} : {1'b0, data == first};
      default:     hit = 2'b00;
    endcase
    return hit;
  endfunction

  // Picks the character to insert for a mode and sequence step
  function automatic logic [7:0] insertChar(input logic [1:0] mode, input logic step,
                                            input logic [7:0] first, input logic [7:0] second);
    return (mode == MODE_SECOND || step) ? second : first;
  endfunction

  // Control fields
  assign uartEnable   = serialControl[BIT_UART_ENABLE];
  assign softMaster   = softFlow[BIT_SOFT_MASTER];
  assign rxMode       = softFlow[POS_RX_MODE +: 2];
  assign txMode       = softFlow[POS_TX_MODE +: 2];
  assign resumeMode   = (softFlow[POS_RESUME_STRAT +: 2] == MODE_OFF) ?
                        rxMode : softFlow[POS_RESUME_STRAT +: 2];
  assign watermark    = fifoLevel[FILL_W-1:0];
  assign triggerLevel = fifoLevel[POS_TRIGGER +: FILL_W];
  assign swTxActive   = softMaster && (txMode != MODE_OFF);

  // Bus handshake: every access waits one cycle, then completes
  assign waitrequest = (read || write) && !ack;
  assign regWrite    = write && ack;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  // Read data captured while the request waits
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      case (address)
        OFF_SERIAL_CONTROL: readdata <= serialControl;
        OFF_SOFT_FLOW:      readdata <= softFlow;
        OFF_FLOW_CHARS:     readdata <= flowChars;
        OFF_DIVISOR:        readdata <= divisor;
        OFF_FIFO_LEVEL:     readdata <= fifoLevel;
        OFF_SERIAL_FLAG:    readdata <= {27'h0000000, !ctsN, !rtsN, insState != INS_IDLE,
                                         txPaused, remoteHalted};
        OFF_RAW_STATUS:     readdata <= {31'h00000000, pauseRaw};
        OFF_INT_MASK:       readdata <= {31'h00000000, pauseMask};
        OFF_MASKED_STATUS:  readdata <= {31'h00000000, pauseRaw && pauseMask};
        default:            readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Software-written configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      serialControl <= RST_SERIAL_CONTROL;
      softFlow      <= RST_SOFT_FLOW;
      flowChars     <= RST_FLOW_CHARS;
      divisor       <= RST_DIVISOR;
      fifoLevel     <= RST_FIFO_LEVEL;
      pauseMask     <= 1'b0;
    end else if (regWrite) begin
      case (address)
        OFF_SERIAL_CONTROL: serialControl <= {28'h0000000, writedata[3:0]};
        OFF_SOFT_FLOW:      softFlow      <= {23'h000000, writedata[8:0]};
        OFF_FLOW_CHARS:     flowChars     <= writedata;
        OFF_DIVISOR:        divisor       <= {10'h000, writedata[21:0]};
        OFF_FIFO_LEVEL:     fifoLevel     <= {17'h00000, writedata[14:8], 1'b0, writedata[6:0]};
        OFF_INT_MASK:       pauseMask     <= writedata[0];
        default:            ;
      endcase
    end
  end

  // Character matching, status bits ignored
  assign matchActive = softMaster && (rxMode != MODE_OFF);
  assign pauseHit    = charMatch(rxMode, rxChar.data, flowChars.pauseFirst,
                                 flowChars.pauseSecond, pausePartial);
  assign resumeHit   = charMatch(resumeMode, rxChar.data, flowChars.resumeFirst,
                                 flowChars.resumeSecond, resumePartial);
  assign specialHit  = rxValid && !softMaster && softFlow[BIT_SPECIAL_CHAR] &&
                       (rxChar.data == flowChars.pauseSecond);
  assign pauseSet    = (rxValid && matchActive && !txPaused && pauseHit[1]) || specialHit;
  assign resumeSet   = rxValid && matchActive && txPaused &&
                       (resumeHit[1] || softFlow[BIT_RESUME_ANY]);

  // Decide which received characters reach the receive FIFO
  always_comb begin
    storeChar = uartEnable && rxValid && (rxFill < FIFO_DEPTH);
    if (matchActive && rxValid) begin
      if (txPaused) begin
        if (!softFlow[BIT_RESUME_ANY] && (resumeHit != 2'b00)) begin
          storeChar = 1'b0;
        end
      end else if (pauseHit != 2'b00) begin
        storeChar = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxStore     <= 1'b0;
      rxStoreChar <= 12'h000;
    end else begin
      rxStore     <= storeChar;
      rxStoreChar <= rxChar;
    end
  end

  // Pause and resume sequencing, half pairs dropped on a mismatch
  always_ff @(posedge clk) begin
    if (rst) begin
      txPaused      <= 1'b0;
      pausePartial  <= 1'b0;
      resumePartial <= 1'b0;
    end else if (!matchActive) begin
      txPaused      <= 1'b0;
      pausePartial  <= 1'b0;
      resumePartial <= 1'b0;
    end else if (rxValid) begin
      if (txPaused) begin
        resumePartial <= resumeHit[0];
        txPaused      <= !resumeSet;
      end else begin
        pausePartial  <= pauseHit[0];
        txPaused      <= pauseHit[1];
      end
    end
  end

  // Raw pause flag: hardware set wins over any clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pauseRaw <= 1'b0;
    end else if (pauseSet) begin
      pauseRaw <= 1'b1;
    end else if (resumeSet) begin
      pauseRaw <= 1'b0;
    end else if (regWrite && address == OFF_RAW_STATUS && writedata[0]) begin
      pauseRaw <= 1'b0;
    end
  end

  // Interrupt line from the masked flag
  always_ff @(posedge clk) begin
    if (rst) begin
      pauseIrq <= 1'b0;
    end else begin
      pauseIrq <= pauseRaw && pauseMask;
    end
  end

  // Request-to-send from the receive watermark
  always_ff @(posedge clk) begin
    if (rst) begin
      rtsN <= 1'b1;
    end else if (serialControl[BIT_REQUEST_FLOW]) begin
      rtsN <= !(rxFill < watermark);
    end else begin
      rtsN <= 1'b0;
    end
  end

  // Transmit start gating
  assign txIdle = !txBusy && !txStart && !startGuard;
  assign ctsOk  = !serialControl[BIT_CLEAR_FLOW] || !ctsN;

  // Automatic pause and resume insertion sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      insState     <= INS_IDLE;
      insResume    <= 1'b0;
      insMode      <= MODE_OFF;
      remoteHalted <= 1'b0;
    end else begin
      case (insState)
        INS_IDLE: begin
          if (swTxActive && !remoteHalted && rxFill >= triggerLevel) begin
            insState  <= INS_FIRST;
            insResume <= 1'b0;
            insMode   <= txMode;
          end else if (remoteHalted && (!swTxActive || rxFill < triggerLevel)) begin
            insState  <= INS_FIRST;
            insResume <= 1'b1;
          end
        end
        INS_FIRST: begin
          if (txIdle && uartEnable && ctsOk) begin
            insState <= (insMode == MODE_BOTH) ? INS_SECOND : INS_DRAIN;
          end
        end
        INS_SECOND: begin
          if (txIdle && uartEnable && ctsOk) begin
            insState <= INS_DRAIN;
          end
        end
        INS_DRAIN: begin
          if (txIdle) begin
            insState     <= INS_IDLE;
            remoteHalted <= !insResume;
          end
        end
        default: insState <= INS_IDLE;
      endcase
    end
  end

  // Start one character: inserted flow characters first, then FIFO data
  always_ff @(posedge clk) begin
    if (rst) begin
      txStart    <= 1'b0;
      txFifoPop  <= 1'b0;
      txByte     <= 8'h00;
      startGuard <= 1'b0;
    end else begin
      startGuard <= txStart;
      txStart    <= 1'b0;
      txFifoPop  <= 1'b0;
      if (txIdle && uartEnable && ctsOk) begin
        if (insState == INS_FIRST || insState == INS_SECOND) begin
          txStart <= 1'b1;
          txByte  <= insResume ?
                     insertChar(insMode, insState == INS_SECOND,
                                flowChars.resumeFirst, flowChars.resumeSecond) :
                     insertChar(insMode, insState == INS_SECOND,
                                flowChars.pauseFirst, flowChars.pauseSecond);
        end else if (!txFifoEmpty && !txPaused && insState == INS_IDLE) begin
          txStart   <= 1'b1;
          txFifoPop <= 1'b1;
          txByte    <= txFifoData;
        end
      end
    end
  end

  // Fractional baud tick generator
  baud_tick_gen baudGen (
    .clk           (clk),
    .rst           (rst),
    .divisorInt    (divisor[DIV_INT_W-1:0]),
    .divisorFrac   (divisor[POS_DIV_FRAC +: DIV_FRAC_W]),
    .oversampleSel (serialControl[BIT_OVERSAMPLE]),
    .sampleTick    (sampleTick),
    .bitTick       (bitTick)
  );

endmodule

//--- verif/remote_link_model.sv
`timescale 1ns/1ps
module remote_link_model (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Framer side
  input wire logic                    txStart,
  output logic                        txBusy,
  // Remote sender
  input wire logic                    rtsN,
  input wire logic                    sendGo,
  input wire uart_flow_pkg::rx_char_s sendWord,
  output logic                        rxValid,
  output uart_flow_pkg::rx_char_s     rxChar
);
  import uart_flow_pkg::*;
  int busyLeft;
  // Framer stays busy a random, sometimes long, time per character
  always_ff @(posedge clk) begin
    if (rst) busyLeft <= 0;
    else if (txStart) busyLeft <= 2 + $urandom_range(25);
    else if (busyLeft > 0) busyLeft <= busyLeft - 1;
  end
  assign txBusy = busyLeft > 0;
  // A character starts only while request is asserted
  always_ff @(posedge clk) begin
    if (rst) rxValid <= 1'b0;
    else rxValid <= sendGo && !rtsN && !rxValid;
  end
  // Outside a character the data lines show the inverse word
  always_ff @(posedge clk) begin
    rxChar <= (sendGo && !rtsN && !rxValid) ? sendWord : ~sendWord;
  end
endmodule

//--- verif/uart_flow_control_tb.sv
`timescale 1ns/1ps
module uart_flow_control_tb;
  import uart_flow_pkg::*;
  logic        clk = 0, rst = 1, read = 0, write = 0, sendGo = 0;
  logic        waitrequest, rxValid, rxStore, txBusy, txFifoPop, txStart;
  logic        sampleTick, bitTick, rtsN, pauseIrq, txFifoEmpty = 1, ctsN = 1;
  logic [5:0]  address = '0;
  logic [6:0]  rxFill = '0;
  logic [7:0]  txFifoData = '0, txByte, lastByte, x;
  logic [31:0] writedata = '0, readdata;
  rx_char_s    rxChar, rxStoreChar, sendWord = '0;
  int          badCount = 0, checksDone = 0, cycles = 0, starts = 0, stores = 0;
  always #20 clk = ~clk;
  uart_flow_control dut_u (.clk, .rst, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .rxValid, .rxChar, .rxFill, .rxStore, .rxStoreChar, .txFifoEmpty,
    .txFifoData, .txBusy, .txFifoPop, .txStart, .txByte, .sampleTick, .bitTick, .ctsN,
    .rtsN, .pauseIrq);
  remote_link_model peer_u (.clk, .rst, .txStart, .txBusy, .rtsN, .sendGo, .sendWord,
    .rxValid, .rxChar);
  // Event counters and timeout
  always @(posedge clk) begin
    cycles++;
    if (txStart === 1'b1) lastByte = txByte;
    if (txStart === 1'b1) starts++;
    if (rxStore === 1'b1) stores++;
    if (cycles == 40000) begin
      badCount++;
      stopTest();
    end
  end
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One access, held until waitrequest is low at an edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, '0, q);
    check(q, e);
  endtask
  // Remote sends one character with random error status
  task automatic sendChar(input logic [7:0] c);
    @(posedge clk);
    sendWord <= {4'($urandom), c};
    sendGo <= 1'b1;
    @(negedge clk);
    while (rxValid !== 1'b1) @(negedge clk);
    @(posedge clk);
    sendGo <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic waitStart(input logic [7:0] e);
    int n;
    n = starts;
    for (int k = 0; k < 400 && starts == n; k++) @(negedge clk);
    check({starts != n, lastByte}, {1'b1, e});
  endtask
  task automatic pollFlag(input logic v);
    logic [31:0] q;
    for (int k = 0; k < 60; k++) begin
      acc(1'b0, OFF_SERIAL_FLAG, '0, q);
      if (q[0] === v) break;
    end
    check(q[0], v);
  endtask
  // Clocks from one bit tick to the next
  task automatic bitGap(input int e);
    int g;
    for (int k = 0; k < 300 && bitTick !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    for (g = 1; g < 300 && bitTick !== 1'b1; g++) @(negedge clk);
    check(g, e);
  endtask
  function automatic logic rtsExp(input logic on, input int f, input int w);
    return on && f >= w;
  endfunction
  // Main sequence
  initial begin
    int wm, n, k;
    void'($urandom(32'hFD9E921F));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdChk(OFF_FLOW_CHARS, RST_FLOW_CHARS);
    rdChk(OFF_FIFO_LEVEL, RST_FIFO_LEVEL);
    rdChk(6'h3C, 32'h0);
    $display("test registers done");
    wm = 1 + $urandom_range(62);
    wr(OFF_FIFO_LEVEL, 32'h2000 | wm);
    wr(OFF_SERIAL_CONTROL, 32'h3);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      rxFill <= (i == 0) ? 7'(wm) : (i == 1) ? 7'(wm - 1) : 7'($urandom_range(64));
      repeat (2) @(negedge clk);
      check(rtsN, rtsExp(1'b1, rxFill, wm));
    end
    wr(OFF_SERIAL_CONTROL, 32'h5);
    repeat (2) @(negedge clk);
    check(rtsN, rtsExp(1'b0, rxFill, wm));
    @(posedge clk);
    rxFill <= '0;
    txFifoData <= 8'($urandom);
    txFifoEmpty <= 1'b0;
    n = starts;
    repeat (50) @(negedge clk);
    check(starts - n, 0);
    @(posedge clk);
    ctsN <= 1'b0;
    waitStart(txFifoData);
    @(posedge clk);
    ctsN <= 1'b1;
    wr(OFF_SERIAL_CONTROL, 32'h1);
    waitStart(txFifoData);
    $display("test hardware flow done");
    x = 8'($urandom);
    wr(OFF_FLOW_CHARS, {x ^ 8'hC3, x, x ^ 8'h3C, x ^ 8'h5A});
    wr(OFF_INT_MASK, 32'h1);
    for (int m = 1; m < 3; m++) begin
      wr(OFF_SOFT_FLOW, 32'(1 + 2 * m));
      n = stores;
      sendChar(m == 1 ? x : x ^ 8'hC3);
      repeat (40) @(negedge clk);
      rdChk(OFF_RAW_STATUS, 32'h1);
      check(pauseIrq, 1'b1);
      k = starts;
      sendChar(x ^ 8'hA5);
      repeat (40) @(negedge clk);
      check(starts - k, 0);
      sendChar(m == 1 ? x ^ 8'h5A : x ^ 8'h3C);
      rdChk(OFF_RAW_STATUS, 32'h0);
      check(pauseIrq, 1'b0);
      check(stores - n, 1);
      waitStart(txFifoData);
    end
    $display("test pause match done");
    @(posedge clk);
    txFifoEmpty <= 1'b1;
    wr(OFF_SOFT_FLOW, 32'h9);
    rxFill <= 7'h20;
    waitStart(x);
    pollFlag(1'b1);
    rxFill <= 7'h1F;
    waitStart(x ^ 8'h5A);
    pollFlag(1'b0);
    rxFill <= 7'h20;
    waitStart(x);
    wr(OFF_SOFT_FLOW, 32'h0);
    waitStart(x ^ 8'h5A);
    pollFlag(1'b0);
    $display("test insertion done");
    wr(OFF_SOFT_FLOW, 32'h27);
    n = stores;
    sendChar(x);
    sendChar(x ^ 8'h11);
    rdChk(OFF_RAW_STATUS, 32'h0);
    sendChar(x);
    sendChar(x ^ 8'hC3);
    rdChk(OFF_RAW_STATUS, 32'h1);
    sendChar(8'($urandom));
    rdChk(OFF_RAW_STATUS, 32'h0);
    check(stores - n, 2);
    $display("test sequential match done");
    wr(OFF_DIVISOR, 32'h2);
    wr(OFF_SERIAL_CONTROL, 32'h9);
    bitGap(2 * 8);
    wr(OFF_SERIAL_CONTROL, 32'h1);
    bitGap(2 * 16);
    $display("test baud ticks done");
    stopTest();
  end
endmodule
bind uart_flow_control uart_flow_sva chk_u (.clk, .rst, .address, .write, .writedata,
  .waitrequest, .rxValid, .rxChar, .rxFill, .rxStore, .rxStoreChar, .txFifoEmpty,
  .txBusy, .txFifoPop, .txStart, .sampleTick, .bitTick, .ctsN, .rtsN);

//--- verif/uart_flow_sva.sv
`timescale 1ns/1ps
module uart_flow_sva (
  // Clock, reset and register writes
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [5:0]              address,
  input wire logic                    write,
  input wire logic [31:0]             writedata,
  input wire logic                    waitrequest,
  // Receive path
  input wire logic                    rxValid,
  input wire uart_flow_pkg::rx_char_s rxChar,
  input wire logic [6:0]              rxFill,
  input wire logic                    rxStore,
  input wire uart_flow_pkg::rx_char_s rxStoreChar,
  // Transmit path, ticks and pins
  input wire logic                    txFifoEmpty,
  input wire logic                    txBusy,
  input wire logic                    txFifoPop,
  input wire logic                    txStart,
  input wire logic                    sampleTick,
  input wire logic                    bitTick,
  input wire logic                    ctsN,
  input wire logic                    rtsN
);
  import uart_flow_pkg::*;
  logic [31:0] ctl;
  logic [6:0]  mark;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the control bits
  always_ff @(posedge clk) begin
    if (rst) ctl <= RST_SERIAL_CONTROL;
    else if (write && !waitrequest && address == OFF_SERIAL_CONTROL) ctl <= writedata;
  end
  // Shadow of the request watermark
  always_ff @(posedge clk) begin
    if (rst) mark <= RST_FIFO_LEVEL[6:0];
    else if (write && !waitrequest && address == OFF_FIFO_LEVEL) mark <= writedata[6:0];
  end
  sequence s_idleBefore; !$past(txBusy); endsequence
  sequence s_noStart; !txStart; endsequence
  property p_rts; !$past(rst) |->
    rtsN == ($past(ctl[BIT_REQUEST_FLOW]) && $past(rxFill) >= $past(mark)); endproperty
  property p_cts; txStart && $past(ctl[BIT_CLEAR_FLOW]) |-> !$past(ctsN); endproperty
  property p_pop; txFifoPop |-> txStart && !$past(txFifoEmpty); endproperty
  property p_gap; txStart |-> s_idleBefore ##1 s_noStart; endproperty
  property p_store; rxStore |-> $past(rxValid) && rxStoreChar == $past(rxChar); endproperty
  property p_full; rxStore |-> $past(rxFill) < FIFO_DEPTH; endproperty
  property p_off; txStart |-> $past(ctl[BIT_UART_ENABLE]); endproperty
  property p_bit; bitTick |-> $past(sampleTick); endproperty
  a_rts: assert property (p_rts) else $error("request pin wrong");
  a_cts: assert property (p_cts) else $error("start without clear");
  a_pop: assert property (p_pop) else $error("bad pop");
  a_gap: assert property (p_gap) else $error("start while busy");
  a_store: assert property (p_store) else $error("bad store");
  a_full: assert property (p_full) else $error("store when full");
  a_off: assert property (p_off) else $error("start while off");
  a_bit: assert property (p_bit) else $error("bit tick alone");
endmodule
